/* sccr_regs.svh */
// Constants for the serial companding control word.
// Assumes inclusion by the design file and its package users.
`ifndef SCCR_REGS_SVH
`define SCCR_REGS_SVH
`define SCCR_PORT_LOWER      3'h0
`define SCCR_PORT_UPPER      3'h1
`define SCCR_FLAG_LSB        0
`define SCCR_FLAG_MSB        3
`define SCCR_MASK_LSB        4
`define SCCR_MASK_MSB        7
`define SCCR_BIT_UPPER_EN    8
`define SCCR_BIT_EXT_FRAME   9
`define SCCR_BIT_USER_OUT    10
`define SCCR_BIT_COMP_MODE   11
`define SCCR_COMP_EN_LSB     12
`define SCCR_COMP_EN_MSB     13
`define SCCR_BIT_ALAW        14
`define SCCR_BIT_SCLK_OUT    15
`define SCCR_MOD_LSB         0
`define SCCR_MOD_MSB         7
`define SCCR_PRE_LSB         8
`define SCCR_PRE_MSB         11
`define SCCR_BIT_LONG_PULSE  12
`define SCCR_IOC_LSB         13
`define SCCR_IOC_MSB         14
`define SCCR_UPPER_WMASK     16'h7FFF
`define SCCR_LOWER_RST       16'h0000
`define SCCR_UPPER_RST       16'h0000
`define SCCR_TWOS_COMP_UPPER 16'h6CBE
`define SCCR_RST_MIN_CYC     5
`define SCCR_IRQ_VECTOR      12'h002
`define SCCR_PC_RESET        12'h000
`define SCCR_FRAME_SRC       3
`define SCCR_LONG_PULSE_LAST 8'h07
`define SCCR_SHORT_PULSE_LAST 8'h00
`endif

/* serial_companding_control_reg.sv */
// Serial companding control word with reset and interrupt entry control.
// Assumes a core issuing port writes/reads on i_clk_sys; pins are asynchronous.
// How it works
// RULE_01: Reset held low five cycles halts execution and zeroes the program counter.
// RULE_02: Software branches from address zero to its init routine.
// RULE_03: Saturation mode, global mask, pointers keep their values through reset.
// RULE_04: Thirty-two bit control word; lower half port 0, upper half port 1.
// RULE_05: Bits 3..0 flags, 7..4 masks, bit 8 upper-half write enable.
// RULE_06: Bits 9..15 framing, output latch, companding fields and clock direction.
// RULE_07: Upper half holds modulus, prescale, pulse width; reserved bits stay zero.
// RULE_08: Port 1 writes reach upper half only while bit 8 set.
// RULE_09: Serial clock pin is input while bit 15 is zero.
// RULE_10: Writing one to a flag clears it.
// RULE_11: Frame counter divides serial clock by programmed modulus; the code divides by the modulus plus one.
// RULE_12: Pulse width bit selects short or long framing pulse.
// RULE_13: Upper value 6CBE selects two's complement companding, 16-bit coprocessor mode.
// RULE_14: Software spaces transmit write and receive read by one instruction.
// RULE_15: Internal framing sets framing flag on every pulse regardless of mask.
// RULE_16: Software writes bits 29 and 30 explicitly.
// RULE_17: Active interrupt source pin sets its flag.
// RULE_18: Four unmasked flags feed one shared pending bit.
// RULE_19: Taking interrupt clears pending, sets mask, pushes PC, loads address 2.
// RULE_20: Writing zero leaves a flag; set mask lets flag raise pending.
`timescale 1ns/100ps
`include "sccr_regs.svh"
package sccr_pkg;
   typedef enum logic [1:0] {
      SCCR_RUN   = 2'b00,
      SCCR_RESET = 2'b01
   } sccr_state_t;
endpackage : sccr_pkg

module serial_companding_control_reg (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic        i_reset_low_pin_n,
   input  wire logic        i_port_wr,
   input  wire logic        i_port_rd,
   input  wire logic [2:0]  i_port_addr,
   input  wire logic [15:0] i_port_wdata,
   input  wire logic        i_irq_take,
   input  wire logic [11:0] i_pc,
   input  wire logic        i_set_global_mask,
   input  wire logic        i_clr_global_mask,
   input  wire logic        i_external_irq_pin_n,
   input  wire logic        i_rx_sync_input_n,
   input  wire logic        i_tx_sync_input_n,
   input  wire logic        i_sclk_tick,
   output logic [15:0]      o_port_rdata,
   output logic [15:0]      o_control_lower,
   output logic [15:0]      o_control_upper,
   output logic             o_halt,
   output logic             o_pc_load,
   output logic [11:0]      o_pc_value,
   output logic             o_push_pc,
   output logic [11:0]      o_push_value,
   output logic             o_irq_pending_bit,
   output logic             o_global_irq_mask,
   output logic             o_sclk_oe,
   output logic             o_user_output_latch,
   output logic             o_sync_pulse,
   output logic             o_twos_comp_mode
);
   logic [2:0]  sync1_reg;
   logic [2:0]  sync2_reg;
   logic [2:0]  sync3_reg;
   logic        rst1_reg;
   logic        rst2_reg;
   logic [2:0]  rst_cnt_reg;
   sccr_pkg::sccr_state_t state_reg;
   logic [15:0] lower_reg;
   logic [15:0] upper_reg;
   logic [7:0]  frame_cnt_reg;
   logic [7:0]  pulse_cnt_reg;
   logic [3:0]  flag_next;
   logic [3:0]  src_edge;
   logic        frame_tick;
   logic        wr_lower;
   logic        wr_upper;
   logic [3:0]  act_now;
   logic [3:0]  act_prev_reg;
   logic        pend_event;

   function automatic logic [3:0] sccr_active(input logic [3:0] f, input logic [3:0] m);
      sccr_active = f & m;
   endfunction : sccr_active

   assign wr_lower = i_port_wr && (i_port_addr == `SCCR_PORT_LOWER);
   assign wr_upper = i_port_wr && (i_port_addr == `SCCR_PORT_UPPER)
                     && lower_reg[`SCCR_BIT_UPPER_EN]; // RULE_08
   assign frame_tick = i_sclk_tick && (frame_cnt_reg == upper_reg[`SCCR_MOD_MSB:`SCCR_MOD_LSB]);
   // Pending raised once per newly active flag
   assign act_now    = sccr_active(lower_reg[`SCCR_FLAG_MSB:`SCCR_FLAG_LSB],
                                   lower_reg[`SCCR_MASK_MSB:`SCCR_MASK_LSB]);
   assign pend_event = |(act_now & ~act_prev_reg); // RULE_18 RULE_20

   // Pin synchronisers
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         sync3_reg <= 3'h0;
         rst1_reg  <= 1'b1;
         rst2_reg  <= 1'b1;
      end else begin
         sync1_reg <= {~i_tx_sync_input_n, ~i_rx_sync_input_n, ~i_external_irq_pin_n};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         rst1_reg  <= i_reset_low_pin_n;
         rst2_reg  <= rst1_reg;
      end
   end

   assign src_edge = {frame_tick && !lower_reg[`SCCR_BIT_EXT_FRAME], sync2_reg & ~sync3_reg}; // RULE_15 RULE_17

   // Reset pin qualification
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         rst_cnt_reg <= 3'h0;
         state_reg   <= sccr_pkg::SCCR_RUN;
      end else begin
         case (state_reg)
            sccr_pkg::SCCR_RUN: begin
               if (rst2_reg) begin
                  rst_cnt_reg <= 3'h0;
               end else if (rst_cnt_reg == 3'(`SCCR_RST_MIN_CYC - 1)) begin
                  state_reg <= sccr_pkg::SCCR_RESET; // RULE_01
               end else begin
                  rst_cnt_reg <= rst_cnt_reg + 3'h1;
               end
            end
            sccr_pkg::SCCR_RESET: begin
               rst_cnt_reg <= 3'h0;
               if (rst2_reg) begin
                  state_reg <= sccr_pkg::SCCR_RUN;
               end
            end
            default: state_reg <= sccr_pkg::SCCR_RUN;
         endcase
      end
   end

   // Flags: set wins over write-one clear
   always_comb begin
      flag_next = lower_reg[`SCCR_FLAG_MSB:`SCCR_FLAG_LSB];
      if (wr_lower) begin
         flag_next = flag_next & ~i_port_wdata[`SCCR_FLAG_MSB:`SCCR_FLAG_LSB]; // RULE_10 RULE_20
      end
      flag_next = flag_next | src_edge; // RULE_17
   end

   // Control word
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || state_reg == sccr_pkg::SCCR_RESET) begin
         lower_reg <= `SCCR_LOWER_RST;
         upper_reg <= `SCCR_UPPER_RST;
      end else begin
         lower_reg[`SCCR_FLAG_MSB:`SCCR_FLAG_LSB] <= flag_next;
         if (wr_lower) begin
            lower_reg[15:`SCCR_MASK_LSB] <= i_port_wdata[15:`SCCR_MASK_LSB]; // RULE_04 RULE_05 RULE_06
         end
         if (wr_upper) begin
            upper_reg <= i_port_wdata & `SCCR_UPPER_WMASK; // RULE_07
         end
      end
   end

   // Frame counter and sync pulse
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || state_reg == sccr_pkg::SCCR_RESET) begin
         frame_cnt_reg <= 8'h00;
         pulse_cnt_reg <= 8'h00;
         o_sync_pulse  <= 1'b0;
      end else begin
         if (i_sclk_tick) begin
            frame_cnt_reg <= frame_tick ? 8'h00 : frame_cnt_reg + 8'h01; // RULE_11
         end
         if (frame_tick) begin
            o_sync_pulse  <= 1'b1;
            pulse_cnt_reg <= upper_reg[`SCCR_BIT_LONG_PULSE] ? `SCCR_LONG_PULSE_LAST
                                                             : `SCCR_SHORT_PULSE_LAST; // RULE_12
         end else if (i_sclk_tick && o_sync_pulse) begin
            if (pulse_cnt_reg == `SCCR_SHORT_PULSE_LAST) begin
               o_sync_pulse <= 1'b0;
            end else begin
               pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
            end
         end
      end
   end

   // Interrupt entry and global mask; mask is not touched by reset
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || state_reg == sccr_pkg::SCCR_RESET) begin
         o_irq_pending_bit <= 1'b0;
         o_push_pc         <= 1'b0;
         o_push_value      <= `SCCR_PC_RESET;
         act_prev_reg      <= 4'h0;
      end else begin
         o_push_pc    <= i_irq_take && o_irq_pending_bit; // RULE_19
         o_push_value <= i_pc;
         act_prev_reg <= act_now;
         if (pend_event) begin
            o_irq_pending_bit <= 1'b1; // RULE_18 RULE_20
         end else if (i_irq_take) begin
            o_irq_pending_bit <= 1'b0; // RULE_19
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_irq_take || i_set_global_mask) begin
         o_global_irq_mask <= 1'b1; // RULE_19 RULE_03
      end else if (i_clr_global_mask) begin
         o_global_irq_mask <= 1'b0;
      end
   end

   // Program counter control and outputs
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_halt      <= 1'b0;
         o_pc_load   <= 1'b0;
         o_pc_value  <= `SCCR_PC_RESET;
         o_port_rdata <= 16'h0000;
      end else begin
         o_halt <= (state_reg == sccr_pkg::SCCR_RESET); // RULE_01
         if (state_reg == sccr_pkg::SCCR_RESET) begin
            o_pc_load  <= 1'b1;
            o_pc_value <= `SCCR_PC_RESET; // RULE_01
         end else if (i_irq_take && o_irq_pending_bit) begin
            o_pc_load  <= 1'b1;
            o_pc_value <= `SCCR_IRQ_VECTOR; // RULE_19
         end else begin
            o_pc_load  <= 1'b0;
         end
         if (i_port_rd) begin
            o_port_rdata <= (i_port_addr == `SCCR_PORT_LOWER) ? lower_reg :
                            (i_port_addr == `SCCR_PORT_UPPER) ? upper_reg : 16'h0000;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_control_lower     <= `SCCR_LOWER_RST;
         o_control_upper     <= `SCCR_UPPER_RST;
         o_sclk_oe           <= 1'b0;
         o_user_output_latch <= 1'b0;
         o_twos_comp_mode    <= 1'b0;
      end else begin
         o_control_lower     <= lower_reg;
         o_control_upper     <= upper_reg;
         o_sclk_oe           <= lower_reg[`SCCR_BIT_SCLK_OUT]; // RULE_09
         o_user_output_latch <= lower_reg[`SCCR_BIT_USER_OUT];
         o_twos_comp_mode    <= (upper_reg == `SCCR_TWOS_COMP_UPPER); // RULE_13
      end
   end

   property p_upper_gate;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_port_wr && i_port_addr == `SCCR_PORT_UPPER && !lower_reg[`SCCR_BIT_UPPER_EN]
       && state_reg == sccr_pkg::SCCR_RUN) |=> $stable(upper_reg);
   endproperty
   a_upper_gate: assert property (p_upper_gate) else $error("upper half written while gated"); // RULE_08
   property p_flag_clear;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (wr_lower && i_port_wdata[`SCCR_FLAG_LSB] && !src_edge[`SCCR_FLAG_LSB]
       && state_reg == sccr_pkg::SCCR_RUN) |=> !lower_reg[`SCCR_FLAG_LSB];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // RULE_10
   property p_frame_flag;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (frame_tick && !lower_reg[`SCCR_BIT_EXT_FRAME] && state_reg == sccr_pkg::SCCR_RUN)
      |=> lower_reg[`SCCR_FRAME_SRC];
   endproperty
   a_frame_flag: assert property (p_frame_flag) else $error("frame flag missing"); // RULE_15
   property p_sclk_dir;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !lower_reg[`SCCR_BIT_SCLK_OUT] |=> !o_sclk_oe;
   endproperty
   a_sclk_dir: assert property (p_sclk_dir) else $error("sclk driven"); // RULE_09
   sequence s_reset_low5;
      !rst2_reg [*5];
   endsequence
   property p_reset_pc;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_reset_low5 |-> ##[1:2] (o_pc_load && o_pc_value == `SCCR_PC_RESET && o_halt);
   endproperty
   a_reset_pc: assert property (p_reset_pc) else $error("reset did not zero pc"); // RULE_01
   property p_irq_entry;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_irq_take && o_irq_pending_bit && state_reg == sccr_pkg::SCCR_RUN)
      |=> (o_pc_value == `SCCR_IRQ_VECTOR && o_push_pc && o_global_irq_mask);
   endproperty
   a_irq_entry: assert property (p_irq_entry) else $error("bad interrupt entry"); // RULE_19
   property p_pending;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (pend_event && state_reg == sccr_pkg::SCCR_RUN) |=> o_irq_pending_bit;
   endproperty
   a_pending: assert property (p_pending) else $error("pending not raised"); // RULE_18
   property p_reserved;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      1'b1 |-> !upper_reg[15];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set"); // RULE_07
   property p_upper_write;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (wr_upper && state_reg == sccr_pkg::SCCR_RUN)
      |=> (upper_reg == ($past(i_port_wdata) & `SCCR_UPPER_WMASK));
   endproperty
   a_upper_write: assert property (p_upper_write) else $error("upper half write lost"); // RULE_08
   property p_pend_clear;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_irq_take && o_irq_pending_bit && !pend_event && state_reg == sccr_pkg::SCCR_RUN)
      |=> !o_irq_pending_bit;
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared on entry"); // RULE_19
endmodule : serial_companding_control_reg

/* sccr_codec_model.sv */
// Codec-side model: prescaled serial clock ticks and active-low sync/irq pins.
// Assumes one system clock; all changes land at its falling edge.
`timescale 1ns/100ps
module sccr_codec_model #(
   parameter int TICK_DIV = 4
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_run,
   output logic            o_sclk_tick,
   output logic [2:0]      o_pins_n
);
   int div_cnt;
   initial begin
      o_sclk_tick = 1'b0;
      o_pins_n = 3'h7;
      div_cnt = 0;
   end
   // Ticks stand still while idle
   always @(negedge i_clk_sys) begin
      if (i_run) begin
         div_cnt = (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
         o_sclk_tick <= (div_cnt == 0);
      end else begin
         div_cnt = 0;
         o_sclk_tick <= 1'b0;
      end
   end
   // Active-low pulse on one pin, idle level high
   task pulse_pin(input int idx);
      @(negedge i_clk_sys);
      o_pins_n[idx] = 1'b0;
      repeat (2) @(negedge i_clk_sys);
      o_pins_n[idx] = 1'b1;
   endtask : pulse_pin
endmodule : sccr_codec_model

/* serial_companding_control_reg_test.sv */
// Self-checking bench for the serial companding control word.
// Assumes the design and its header are compiled first.
`timescale 1ns/100ps
`include "sccr_regs.svh"
module serial_companding_control_reg_test;
   logic        i_clk_sys, i_rst_n, i_reset_low_pin_n, i_port_wr, i_port_rd, i_irq_take, run;
   logic        i_set_global_mask, i_clr_global_mask;
   logic [2:0]  i_port_addr;
   logic [15:0] i_port_wdata, o_port_rdata, o_control_lower, o_control_upper, v, d, exp_up;
   logic [11:0] i_pc, o_pc_value, o_push_value;
   logic        o_halt, o_pc_load, o_push_pc, o_irq_pending_bit, o_global_irq_mask;
   logic        o_sclk_oe, o_user_output_latch, o_sync_pulse, o_twos_comp_mode;
   wire logic       i_sclk_tick;
   wire logic [2:0] pins_n;
   wire logic       i_external_irq_pin_n = pins_n[0];
   wire logic       i_rx_sync_input_n = pins_n[1];
   wire logic       i_tx_sync_input_n = pins_n[2];
   int          err_total, checks_done, k, per, hi;
   serial_companding_control_reg u_dut (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reset_low_pin_n(i_reset_low_pin_n), .i_port_wr(i_port_wr),
      .i_port_rd(i_port_rd), .i_port_addr(i_port_addr), .i_port_wdata(i_port_wdata), .i_irq_take(i_irq_take),
      .i_pc(i_pc), .i_set_global_mask(i_set_global_mask), .i_clr_global_mask(i_clr_global_mask),
      .i_external_irq_pin_n(i_external_irq_pin_n), .i_rx_sync_input_n(i_rx_sync_input_n),
      .i_tx_sync_input_n(i_tx_sync_input_n), .i_sclk_tick(i_sclk_tick), .o_port_rdata(o_port_rdata),
      .o_control_lower(o_control_lower), .o_control_upper(o_control_upper), .o_halt(o_halt),
      .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_push_pc(o_push_pc), .o_push_value(o_push_value),
      .o_irq_pending_bit(o_irq_pending_bit), .o_global_irq_mask(o_global_irq_mask), .o_sclk_oe(o_sclk_oe),
      .o_user_output_latch(o_user_output_latch), .o_sync_pulse(o_sync_pulse),
      .o_twos_comp_mode(o_twos_comp_mode)
   );
   sccr_codec_model u_codec (.i_clk_sys(i_clk_sys), .i_run(run), .o_sclk_tick(i_sclk_tick), .o_pins_n(pins_n));
   always #2.5 i_clk_sys = ~i_clk_sys;
   function automatic logic [15:0] f_up(input logic [15:0] old, input logic [15:0] x, input logic en);
      return en ? (x & 16'h7FFF) : old;
   endfunction : f_up
   task test_done;
      $display("Checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task guard(input int n);
      if (k >= n) begin
         err_total++;
         $display("ERROR t=%0t wait limit %h %h", $time, k, n);
         test_done();
      end
   endtask : guard
   task wr(input logic [2:0] a, input logic [15:0] x);
      i_port_addr = a;
      i_port_wdata = x;
      i_port_wr = 1'b1;
      @(negedge i_clk_sys);
      i_port_wr = 1'b0;
      @(negedge i_clk_sys);
   endtask : wr
   task rd(input logic [2:0] a);
      i_port_addr = a;
      i_port_rd = 1'b1;
      @(negedge i_clk_sys);
      i_port_rd = 1'b0;
      @(negedge i_clk_sys);
      v = o_port_rdata;
   endtask : rd
   // Align to a sync pulse rise, then time high part and full period
   task measure;
      for (k = 0; k < 400 && o_sync_pulse !== 1'b0; k++) @(negedge i_clk_sys);
      for (; k < 400 && o_sync_pulse !== 1'b1; k++) @(negedge i_clk_sys);
      guard(400);
      for (hi = 0; hi < 400 && o_sync_pulse === 1'b1; hi++) @(negedge i_clk_sys);
      for (per = hi; per < 400 && o_sync_pulse === 1'b0; per++) @(negedge i_clk_sys);
      k = per;
      guard(400);
   endtask : measure
   task pin_reset(input int n);
      i_reset_low_pin_n = 1'b0;
      repeat (n) @(negedge i_clk_sys);
   endtask : pin_reset
   initial begin
      {i_clk_sys, i_rst_n, i_port_wr, i_port_rd, i_irq_take, run} = 6'h00;
      {i_set_global_mask, i_clr_global_mask, i_port_addr, i_pc} = 17'h0_0000;
      i_reset_low_pin_n = 1'b1;
      i_port_wdata = 16'h0000;
      err_total = 0;
      checks_done = 0;
      void'($urandom(6582));
      repeat (12) @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      @(negedge i_clk_sys);
      wr(`SCCR_PORT_UPPER, 16'h1CFE);
      chk(o_control_upper, 16'h0000);
      wr(`SCCR_PORT_LOWER, 16'h3988);
      chk(o_control_lower, 16'h3980);
      chk({15'h0000, o_sclk_oe}, 16'h0000);
      wr(`SCCR_PORT_UPPER, 16'h1CFE);
      rd(`SCCR_PORT_UPPER);
      chk(v, 16'h1CFE);
      rd(3'h2);
      chk(v, 16'h0000);
      wr(`SCCR_PORT_UPPER, 16'hFFFF);
      chk(o_control_upper, 16'h7FFF);
      wr(`SCCR_PORT_UPPER, `SCCR_TWOS_COMP_UPPER);
      chk({15'h0000, o_twos_comp_mode}, 16'h0001);
      exp_up = `SCCR_TWOS_COMP_UPPER;
      for (int i = 0; i < 16; i++) begin
         d = 16'($urandom);
         wr(`SCCR_PORT_LOWER, d);
         chk(o_control_lower, d & 16'hFFF0);
         chk({14'h0000, o_sclk_oe, o_user_output_latch}, {14'h0000, d[15], d[10]});
         v = 16'($urandom) & 16'h7FFF;
         wr(`SCCR_PORT_UPPER, v);
         exp_up = f_up(exp_up, v, d[8]);
         chk(o_control_upper, exp_up);
         chk({15'h0000, o_twos_comp_mode}, {15'h0000, exp_up == 16'h6CBE});
      end
      for (int i = 0; i < 3; i++) begin
         wr(`SCCR_PORT_LOWER, 16'h0100 | (16'h0010 << i));
         u_codec.pulse_pin(i);
         for (k = 0; k < 20 && o_irq_pending_bit !== 1'b1; k++) @(negedge i_clk_sys);
         guard(20);
         chk(o_control_lower, 16'h0100 | (16'h0011 << i));
         wr(`SCCR_PORT_LOWER, 16'h0100 | (16'h0010 << i));
         chk(o_control_lower, 16'h0100 | (16'h0011 << i));
         i_pc = 12'($urandom);
         i_irq_take = 1'b1;
         @(negedge i_clk_sys);
         i_irq_take = 1'b0;
         chk({12'h000, o_pc_load, o_push_pc, o_irq_pending_bit, o_global_irq_mask}, 16'h000D);
         chk({4'h0, o_pc_value}, {4'h0, `SCCR_IRQ_VECTOR});
         chk({4'h0, o_push_value}, {4'h0, i_pc});
         i_clr_global_mask = 1'b1;
         @(negedge i_clk_sys);
         i_clr_global_mask = 1'b0;
         chk({15'h0000, o_global_irq_mask}, 16'h0000);
         wr(`SCCR_PORT_LOWER, 16'h0100 | (16'h0001 << i));
         chk(o_control_lower, 16'h0100);
      end
      wr(`SCCR_PORT_UPPER, 16'h0003);
      run = 1'b1;
      measure();
      measure();
      chk(16'(per), 16'h0010);
      chk(16'(hi), 16'h0004);
      chk(o_control_lower & 16'h0008, 16'h0008);
      wr(`SCCR_PORT_UPPER, 16'h100B);
      measure();
      measure();
      chk(16'(per), 16'h0030);
      chk(16'(hi), 16'h0020);
      run = 1'b0;
      i_set_global_mask = 1'b1;
      @(negedge i_clk_sys);
      i_set_global_mask = 1'b0;
      pin_reset(3);
      i_reset_low_pin_n = 1'b1;
      hi = 0;
      repeat (8) @(negedge i_clk_sys) if (o_halt !== 1'b0) hi++;
      chk(16'(hi), 16'h0000);
      pin_reset(9);
      chk({13'h0000, o_halt, o_pc_load, o_global_irq_mask}, 16'h0007);
      chk({4'h0, o_pc_value}, {4'h0, `SCCR_PC_RESET});
      chk(o_control_lower | o_control_upper, 16'h0000);
      i_reset_low_pin_n = 1'b1;
      for (k = 0; k < 10 && o_halt !== 1'b0; k++) @(negedge i_clk_sys);
      guard(10);
      chk({15'h0000, o_global_irq_mask}, 16'h0001);
      wr(`SCCR_PORT_LOWER, 16'h3988);
      wr(`SCCR_PORT_UPPER, 16'h1CFE);
      rd(`SCCR_PORT_LOWER);
      chk(v, 16'h3980);
      chk(o_control_upper, 16'h1CFE);
      test_done();
   end
endmodule : serial_companding_control_reg_test
